//--- include/fcdma_pkg.sv
// constants and types shared by the four-channel dma controller
package fcdma_pkg;
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int MODE_W = 2;

  // transfer modes, as driven on the per-channel mode port
  localparam logic [1:0] MODE_DEMAND = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_BLOCK = 2'h2;

  // direction bit
  localparam logic DIR_IO_TO_MEM = 1'h0;
  localparam logic DIR_MEM_TO_IO = 1'h1;

  // byte pacing against the peak rate
  localparam int CLK_HZ = 125_000_000;
  localparam int PEAK_BYTES_PER_S = 2_000_000;
  localparam int BYTE_CYCLES = (CLK_HZ + PEAK_BYTES_PER_S - 1) / PEAK_BYTES_PER_S;
  localparam int PACE_W = 7;

  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  // two-entry buffer depth
  localparam int BUF_DEPTH = 2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HOLD,
    ST_ISSUE,
    ST_WAIT,
    ST_CAPTURE,
    ST_STEP
  } fcdma_state_t;
endpackage

//--- hdl/fcdma_skid.sv
// two-entry buffer between the engine and the output device
`timescale 1ns/1ns
module fcdma_skid #(
  parameter int W = 8
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [1:0] count;
  logic [1:0] next_count;
  logic [W-1:0] tail;
  logic [W-1:0] next_tail;
  logic [W-1:0] next_out_data;
  logic next_out_valid;
  logic push;
  logic pop;

  always_comb begin
    in_ready = (count != 2'(fcdma_pkg::BUF_DEPTH));
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_count = count;
    next_tail = tail;
    next_out_data = out_data;
    case ({push, pop})
      2'b10: begin
        if (count == 2'h0) begin
          next_out_data = in_data;
        end else begin
          next_tail = in_data;
        end
        next_count = count + 2'h1;
      end
      2'b01: begin
        next_out_data = tail;
        next_count = count - 2'h1;
      end
      2'b11: begin
        // only reachable with one entry held
        next_out_data = in_data;
      end
      default: begin
      end
    endcase
    next_out_valid = (next_count != 2'h0);
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      count <= 2'h0;
      tail <= '0;
      out_data <= '0;
      out_valid <= 1'b0;
    end else begin
      count <= next_count;
      tail <= next_tail;
      out_data <= next_out_data;
      out_valid <= next_out_valid;
    end
  end
endmodule

//--- hdl/fcdma_top.sv
// four-channel dma transfer engine with hold handshake and output buffer
`timescale 1ns/1ns
module fcdma_top #(
  parameter int N_CH = fcdma_pkg::NUM_CH,
  parameter int AW = fcdma_pkg::ADDR_W,
  parameter int DW = fcdma_pkg::DATA_W
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [N_CH-1:0] ch_load,
  input wire logic [N_CH-1:0] ch_sw_req,
  input wire logic [N_CH-1:0] ch_dir,
  input wire logic [N_CH-1:0] ch_addr_dec,
  input wire logic [N_CH-1:0] ch_autoinit,
  input wire logic [N_CH-1:0][1:0] ch_mode,
  input wire logic [N_CH-1:0][AW-1:0] ch_base_addr,
  input wire logic [N_CH-1:0][AW-1:0] ch_base_count,
  input wire logic mem2mem_en,
  input wire logic [N_CH-1:0] dreq,
  output logic [N_CH-1:0] dack,
  output logic hold_req,
  input wire logic hold_ack,
  output logic [AW-1:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [DW-1:0] mem_wdata,
  input wire logic [DW-1:0] mem_rdata,
  input wire logic [DW-1:0] io_in_data,
  input wire logic io_in_valid,
  output logic io_in_ack,
  output logic [DW-1:0] io_out_data,
  output logic io_out_valid,
  input wire logic io_out_ready,
  output logic [N_CH-1:0] ch_active,
  output logic [N_CH-1:0] ch_tc
);
  localparam int CW = (N_CH > 1) ? $clog2(N_CH) : 1;

  function automatic logic [AW-1:0] step_addr(input logic [AW-1:0] a, input logic dec);
    step_addr = dec ? a - AW'(1) : a + AW'(1);
  endfunction

  function automatic logic [CW-1:0] pick_first(input logic [N_CH-1:0] v);
    pick_first = '0;
    for (int i = N_CH - 1; i >= 0; i--) begin
      if (v[i]) begin
        pick_first = CW'(i);
      end
    end
  endfunction

  // dreq and hold_ack pin inputs pass two flops
  logic [N_CH-1:0] dreq_m;
  logic [N_CH-1:0] dreq_s;
  logic hold_ack_m;
  logic hold_ack_s;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      dreq_m <= '0;
      dreq_s <= '0;
      hold_ack_m <= 1'b0;
      hold_ack_s <= 1'b0;
    end else begin
      dreq_m <= dreq;
      dreq_s <= dreq_m;
      hold_ack_m <= hold_ack;
      hold_ack_s <= hold_ack_m;
    end
  end

  logic [N_CH-1:0][AW-1:0] cur_addr;
  logic [N_CH-1:0][AW-1:0] next_cur_addr;
  logic [N_CH-1:0][AW-1:0] cur_count;
  logic [N_CH-1:0][AW-1:0] next_cur_count;
  logic [N_CH-1:0] sw_pend;
  logic [N_CH-1:0] next_sw_pend;
  logic [N_CH-1:0] next_ch_active;
  logic [N_CH-1:0] next_ch_tc;
  fcdma_pkg::fcdma_state_t state;
  fcdma_pkg::fcdma_state_t next_state;
  logic [CW-1:0] chan;
  logic [CW-1:0] next_chan;
  logic m2m_run;
  logic next_m2m_run;
  logic [fcdma_pkg::PACE_W-1:0] pace;
  logic [fcdma_pkg::PACE_W-1:0] next_pace;
  logic [N_CH-1:0] next_dack;
  logic next_hold_req;
  logic [AW-1:0] next_mem_addr;
  logic next_mem_rd;
  logic next_mem_wr;
  logic [DW-1:0] next_mem_wdata;
  logic next_io_in_ack;
  logic [N_CH-1:0] pending;
  logic [N_CH-1:0] m2m_mask;
  logic step;
  logic tc;
  logic req_now;
  logic byte_start;
  logic [AW-1:0] stepped_addr;
  logic [AW-1:0] stepped_dst;
  logic buf_in_valid;
  logic buf_in_ready;

  fcdma_skid #(
    .W(DW)
  ) u_out_buf (
    .clock(clock),
    .reset_n(reset_n),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(mem_rdata),
    .out_valid(io_out_valid),
    .out_ready(io_out_ready),
    .out_data(io_out_data)
  );

  // request arbitration inputs
  always_comb begin
    m2m_mask = '1;
    if (mem2mem_en && N_CH > 1) begin
      m2m_mask[1] = 1'b0;
    end
    pending = ch_active & (dreq_s | sw_pend) & m2m_mask;
    step = (state == fcdma_pkg::ST_STEP);
    tc = (cur_count[chan] == '0);
    req_now = dreq_s[chan] | sw_pend[chan];
    stepped_addr = step_addr(cur_addr[chan], ch_addr_dec[chan]);
    stepped_dst = step_addr(cur_addr[1], ch_addr_dec[1]);
  end

  always_comb begin
    next_cur_addr = cur_addr;
    next_cur_count = cur_count;
    next_sw_pend = sw_pend;
    next_ch_active = ch_active;
    next_ch_tc = '0;
    for (int i = 0; i < N_CH; i++) begin
      if (step && chan == CW'(i)) begin
        if (tc) begin
          next_ch_tc[i] = 1'b1;
          next_sw_pend[i] = 1'b0;
          if (ch_autoinit[i]) begin
            next_cur_addr[i] = ch_base_addr[i];
            next_cur_count[i] = ch_base_count[i];
          end else begin
            next_ch_active[i] = 1'b0;
          end
        end else begin
          next_cur_addr[i] = stepped_addr;
          next_cur_count[i] = cur_count[i] - AW'(1);
        end
      end
      if (ch_load[i]) begin
        next_cur_addr[i] = ch_base_addr[i];
        next_cur_count[i] = ch_base_count[i];
        next_ch_active[i] = 1'b1;
      end
      // set wins over the terminal-count clear while the channel stays active
      if (ch_sw_req[i] && next_ch_active[i]) begin
        next_sw_pend[i] = 1'b1;
      end
    end
    // destination walks with channel 1 settings
    if (step && m2m_run && !tc && N_CH > 1) begin
      next_cur_addr[1] = stepped_dst;
    end
  end

  // transfer sequencer
  always_comb begin
    next_state = state;
    next_chan = chan;
    next_m2m_run = m2m_run;
    next_pace = (pace != '0) ? pace - fcdma_pkg::PACE_W'(1) : pace;
    next_dack = dack;
    next_hold_req = hold_req;
    next_mem_addr = mem_addr;
    next_mem_rd = 1'b0;
    next_mem_wr = 1'b0;
    next_mem_wdata = mem_wdata;
    next_io_in_ack = 1'b0;
    buf_in_valid = 1'b0;
    byte_start = 1'b0;
    case (state)
      fcdma_pkg::ST_IDLE: begin
        if (pending != '0 && !hold_ack_s) begin
          next_chan = pick_first(pending);
          next_dack = '0;
          next_dack[pick_first(pending)] = 1'b1;
          next_hold_req = 1'b1;
          next_m2m_run = mem2mem_en && (pick_first(pending) == '0);
          next_state = fcdma_pkg::ST_HOLD;
        end
      end
      fcdma_pkg::ST_HOLD: begin
        // bus is ours only after hold is granted
        if (hold_ack_s) begin
          next_state = fcdma_pkg::ST_ISSUE;
        end
      end
      fcdma_pkg::ST_ISSUE: begin
        if (pace == '0) begin
          if (m2m_run || ch_dir[chan] == fcdma_pkg::DIR_MEM_TO_IO) begin
            if (m2m_run || buf_in_ready) begin
              byte_start = 1'b1;
              next_mem_rd = 1'b1;
              next_mem_addr = cur_addr[chan];
              next_state = fcdma_pkg::ST_WAIT;
            end
          end else if (io_in_valid) begin
            byte_start = 1'b1;
            next_mem_wr = 1'b1;
            next_mem_addr = cur_addr[chan];
            next_mem_wdata = io_in_data;
            next_io_in_ack = 1'b1;
            next_state = fcdma_pkg::ST_STEP;
          end
          if (byte_start) begin
            next_pace = fcdma_pkg::PACE_W'(fcdma_pkg::BYTE_CYCLES - 1);
          end
        end
      end
      fcdma_pkg::ST_WAIT: begin
        next_state = fcdma_pkg::ST_CAPTURE;
      end
      fcdma_pkg::ST_CAPTURE: begin
        if (m2m_run) begin
          next_mem_wr = 1'b1;
          next_mem_addr = cur_addr[1];
          next_mem_wdata = mem_rdata;
        end else begin
          buf_in_valid = 1'b1;
        end
        next_state = fcdma_pkg::ST_STEP;
      end
      fcdma_pkg::ST_STEP: begin
        next_state = fcdma_pkg::ST_IDLE;
        if (!tc) begin
          // block and copy keep the bus
          if (m2m_run || ch_mode[chan] == fcdma_pkg::MODE_BLOCK) begin
            next_state = fcdma_pkg::ST_ISSUE;
          end else if (ch_mode[chan] == fcdma_pkg::MODE_DEMAND && req_now) begin
            next_state = fcdma_pkg::ST_ISSUE;
          end
        end
        // single mode falls through to release
        if (next_state == fcdma_pkg::ST_IDLE) begin
          next_hold_req = 1'b0;
          next_dack = '0;
        end
      end
      default: begin
        next_state = fcdma_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cur_addr <= '0;
      cur_count <= '0;
      sw_pend <= '0;
      ch_active <= '0;
      ch_tc <= '0;
      state <= fcdma_pkg::ST_IDLE;
      chan <= '0;
      m2m_run <= 1'b0;
      pace <= '0;
      dack <= '0;
      hold_req <= 1'b0;
      mem_addr <= fcdma_pkg::ADDR_RESET;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_wdata <= fcdma_pkg::DATA_RESET;
      io_in_ack <= 1'b0;
    end else begin
      cur_addr <= next_cur_addr;
      cur_count <= next_cur_count;
      sw_pend <= next_sw_pend;
      ch_active <= next_ch_active;
      ch_tc <= next_ch_tc;
      state <= next_state;
      chan <= next_chan;
      m2m_run <= next_m2m_run;
      pace <= next_pace;
      dack <= next_dack;
      hold_req <= next_hold_req;
      mem_addr <= next_mem_addr;
      mem_rd <= next_mem_rd;
      mem_wr <= next_mem_wr;
      mem_wdata <= next_mem_wdata;
      io_in_ack <= next_io_in_ack;
    end
  end

  // cycles since the last byte start, for the rate check
  localparam int MIN_GAP = fcdma_pkg::BYTE_CYCLES;
  logic [7:0] since_start;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      since_start <= 8'hFF;
    end else if (byte_start) begin
      since_start <= 8'h01;
    end else if (since_start != 8'hFF) begin
      since_start <= since_start + 8'h01;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  hold_before_bus_a: assert property (
    (mem_rd || mem_wr) |-> hold_req && hold_ack_s && $onehot(dack))
    else $error("bus cycle without hold and acknowledge");
  one_grant_a: assert property (
    $onehot0(dack))
    else $error("more than one channel acknowledged");
  priority_a: assert property (
    (state == fcdma_pkg::ST_IDLE && pending != '0 && !hold_ack_s)
      |=> dack == ($past(pending) & -$past(pending)))
    else $error("grant not given to highest priority channel");
  peak_rate_a: assert property (
    byte_start |-> since_start >= 8'(MIN_GAP))
    else $error("byte starts closer than peak rate allows");
  addr_step_a: assert property (
    step && !tc |=> cur_addr[$past(chan)] == $past(stepped_addr))
    else $error("address did not step by one");
  count_dec_a: assert property (
    step && !tc |=> cur_count[$past(chan)] == $past(cur_count[chan]) - AW'(1) ##0 ch_tc == '0)
    else $error("count did not decrement");
  autoinit_a: assert property (
    step && tc && ch_autoinit[chan] |=> ch_active[$past(chan)] && ch_tc[$past(chan)])
    else $error("auto-initialized channel went inactive");
  block_keep_a: assert property (
    step && !tc && ch_mode[chan] == fcdma_pkg::MODE_BLOCK |=> hold_req [*2])
    else $error("block mode released the bus early");
  demand_pause_a: assert property (
    step && !tc && !m2m_run && ch_mode[chan] == fcdma_pkg::MODE_DEMAND && !req_now
      |=> !hold_req && dack == '0)
    else $error("demand mode did not pause");
  single_release_a: assert property (
    step && !m2m_run && ch_mode[chan] == fcdma_pkg::MODE_SINGLE |=> !hold_req ##1 !mem_rd && !mem_wr)
    else $error("single mode kept the bus");
  io_dir_a: assert property (
    io_in_ack |-> mem_wr && ch_dir[chan] == fcdma_pkg::DIR_IO_TO_MEM)
    else $error("input taken on an output channel");
  copy_dst_a: assert property (
    mem_wr && m2m_run |-> mem_addr == cur_addr[1] && $past(mem_rd, 2))
    else $error("copy write not after read at destination");
  sw_start_a: assert property (
    ch_sw_req[0] && ch_active[0] && !ch_load[0] |=> sw_pend[0] || ch_tc[0])
    else $error("software request lost");

  cover_single_c: cover property (step && ch_mode[chan] == fcdma_pkg::MODE_SINGLE);
  cover_block_tc_c: cover property (step && tc && ch_mode[chan] == fcdma_pkg::MODE_BLOCK);
  cover_copy_c: cover property (mem_wr && m2m_run);
  cover_stall_c: cover property (io_out_valid && !io_out_ready && !buf_in_ready);
endmodule

//--- verif/fcdma_partner.sv
// memory, cpu hold and io device models on the far side of the dma engine
`timescale 1ns/1ns
module fcdma_partner (
  input wire logic clock,
  input wire logic hold_req,
  output logic hold_ack,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic [7:0] io_in_data,
  output logic io_in_valid,
  input wire logic io_in_ack,
  input wire logic in_en,
  input wire logic [7:0] io_out_data,
  input wire logic io_out_valid,
  output logic io_out_ready,
  input wire logic out_stall,
  input wire logic [3:0] hold_lat
);
  logic [7:0] mem [0:65535];
  logic [7:0] out_q [$];
  logic [7:0] in_seq = 8'h00;
  int hcnt = 0;
  int bus_bad = 0;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'h3C;
    end
    hold_ack = 1'b0;
    mem_rdata = 8'h00;
    io_in_data = 8'h00;
    io_in_valid = 1'b0;
    io_out_ready = 1'b0;
  end
  // cpu yields after its latency, stays off until hold drops
  always @(posedge clock) begin
    hcnt <= hold_req ? hcnt + 1 : 0;
    // latency in steps of 8 cycles
    hold_ack <= hold_req && hcnt >= 8 * int'(hold_lat);
    if ((mem_rd || mem_wr) && hold_ack !== 1'b1) bus_bad <= bus_bad + 1;
  end
  // idle data lines toggle so a stale byte never looks good
  always @(posedge clock) begin
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
    if (mem_wr) mem[mem_addr] <= mem_wdata;
    if (io_out_valid && io_out_ready) out_q.push_back(io_out_data);
    io_out_ready <= !out_stall;
    if (io_in_ack) in_seq <= in_seq + 8'h01;
    io_in_valid <= in_en;
    io_in_data <= in_en ? 8'hA0 + in_seq + {7'h00, io_in_ack} : ~io_in_data;
  end
endmodule

//--- verif/tb_four_channel_dma_controller.sv
// self-checking bench for the four-channel dma engine
`timescale 1ns/1ns
module tb_four_channel_dma_controller;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic mem2mem_en = 1'b0;
  logic in_en = 1'b0;
  logic out_stall = 1'b0;
  logic hold_q = 1'b0;
  logic first_hold = 1'b0;
  logic hold_ack, hold_req, mem_rd, mem_wr, io_in_valid, io_in_ack, io_out_valid, io_out_ready;
  logic [3:0] ch_load = 4'h0, ch_sw_req = 4'h0, ch_dir = 4'h0, ch_addr_dec = 4'h0;
  logic [3:0] ch_autoinit = 4'h0, dreq = 4'h0, hold_lat = 4'h1, first_dack = 4'h0;
  logic [3:0] dack, ch_active, ch_tc;
  logic [3:0][1:0] ch_mode = 8'h00;
  logic [3:0][15:0] ch_base_addr = 64'h0, ch_base_count = 64'h0;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata, io_in_data, io_out_data;
  int errors = 0, cmp_count = 0, cyc = 0, rd_last = -1, rd_gap = 1000, hold_falls = 0, acks = 0;

  fcdma_top fcdma_top_inst (.clock, .reset_n, .ch_load, .ch_sw_req, .ch_dir, .ch_addr_dec,
    .ch_autoinit, .ch_mode, .ch_base_addr, .ch_base_count, .mem2mem_en, .dreq, .dack,
    .hold_req, .hold_ack, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .io_in_data,
    .io_in_valid, .io_in_ack, .io_out_data, .io_out_valid, .io_out_ready, .ch_active, .ch_tc);
  fcdma_partner fcdma_partner_inst (.clock, .hold_req, .hold_ack, .mem_addr, .mem_rd, .mem_wr,
    .mem_wdata, .mem_rdata, .io_in_data, .io_in_valid, .io_in_ack, .in_en, .io_out_data,
    .io_out_valid, .io_out_ready, .out_stall, .hold_lat);

  always #4 clock = ~clock;
  // gaps between reads, hold releases, input acks, first grant
  always @(posedge clock) begin
    cyc <= cyc + 1;
    hold_q <= hold_req;
    if (hold_q === 1'b1 && hold_req === 1'b0) hold_falls <= hold_falls + 1;
    if (io_in_ack === 1'b1) acks <= acks + 1;
    if (mem_rd === 1'b1) rd_last <= cyc;
    if (mem_rd === 1'b1 && rd_last >= 0 && cyc - rd_last < rd_gap) rd_gap <= cyc - rd_last;
    if (dack !== 4'h0 && first_dack === 4'h0) first_dack <= dack;
    if (dack !== 4'h0 && first_dack === 4'h0) first_hold <= hold_req;
  end

  function automatic logic [15:0] mem(input logic [15:0] a);
    return {8'h00, fcdma_partner_inst.mem[a]};
  endfunction
  function automatic logic [15:0] oq(input int i);
    return {8'h00, fcdma_partner_inst.out_q[i]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic tick(inout int n);
    @(posedge clock);
    #1;
    n++;
    if (n > 3000) begin
      errors++;
      close_out();
    end
  endtask

  task automatic wait_tc(input int ch);
    int n;
    n = 0;
    while (ch_tc[ch] !== 1'b1) tick(n);
    @(negedge clock);
  endtask

  task automatic load(input int ch, input logic dir, input logic dec, input logic [1:0] md,
      input logic au, input logic [15:0] a, input logic [15:0] n);
    @(negedge clock);
    ch_dir[ch] = dir;
    ch_addr_dec[ch] = dec;
    ch_mode[ch] = md;
    ch_autoinit[ch] = au;
    ch_base_addr[ch] = a;
    ch_base_count[ch] = n;
    ch_load[ch] = 1'b1;
    @(negedge clock);
    ch_load = 4'h0;
  endtask

  task automatic sw(input logic [3:0] m);
    @(negedge clock);
    ch_sw_req = m;
    @(negedge clock);
    ch_sw_req = 4'h0;
  endtask

  task automatic t_block_out();
    int f;
    f = hold_falls;
    out_stall = 1'b1;
    load(0, 1'b1, 1'b0, fcdma_pkg::MODE_BLOCK, 1'b0, 16'h1200, 16'h0003);
    sw(4'h1);
    repeat (400) @(negedge clock);
    check(16'(fcdma_partner_inst.out_q.size()), 16'h0000);
    check({15'h0, io_out_valid}, 16'h0001);
    out_stall = 1'b0;
    wait_tc(0);
    repeat (8) @(negedge clock);
    check(16'(fcdma_partner_inst.out_q.size()), 16'h0004);
    for (int i = 0; i < 4; i++) check(oq(i), {8'h00, 8'(i) ^ 8'h3C});
    check(16'(rd_gap >= fcdma_pkg::BYTE_CYCLES), 16'h0001);
    check(16'(hold_falls - f), 16'h0001);
    check({15'h0, ch_active[0]}, 16'h0000);
    $display("block output test done");
  endtask

  task automatic t_single_in();
    int f;
    logic [7:0] b;
    f = hold_falls;
    b = fcdma_partner_inst.in_seq;
    in_en = 1'b1;
    load(2, 1'b0, 1'b1, fcdma_pkg::MODE_SINGLE, 1'b0, 16'h3401, 16'h0001);
    dreq[2] = 1'b1;
    wait_tc(2);
    dreq[2] = 1'b0;
    in_en = 1'b0;
    repeat (6) @(negedge clock);
    check(mem(16'h3401), {8'h00, 8'(8'hA0 + b)});
    check(mem(16'h3400), {8'h00, 8'(8'hA1 + b)});
    check(16'(hold_falls - f), 16'h0002);
    $display("single input test done");
  endtask

  task automatic t_demand();
    int n, a0, k;
    logic [7:0] b;
    b = fcdma_partner_inst.in_seq;
    a0 = acks;
    n = 0;
    in_en = 1'b1;
    load(3, 1'b0, 1'b0, fcdma_pkg::MODE_DEMAND, 1'b0, 16'h5600, 16'h0004);
    dreq[3] = 1'b1;
    while (acks - a0 < 2) tick(n);
    @(negedge clock);
    dreq[3] = 1'b0;
    repeat (100) @(negedge clock);
    k = acks;
    check({15'h0, hold_req}, 16'h0000);
    check({15'h0, ch_active[3]}, 16'h0001);
    repeat (100) @(negedge clock);
    check(16'(acks - k), 16'h0000);
    dreq[3] = 1'b1;
    wait_tc(3);
    dreq[3] = 1'b0;
    in_en = 1'b0;
    repeat (6) @(negedge clock);
    check(16'(acks - a0), 16'h0005);
    check(mem(16'h5604), {8'h00, 8'(8'hA4 + b)});
    $display("demand test done");
  endtask

  task automatic t_copy();
    @(negedge clock);
    mem2mem_en = 1'b1;
    load(1, 1'b0, 1'b0, fcdma_pkg::MODE_BLOCK, 1'b0, 16'h7800, 16'h0001);
    load(0, 1'b0, 1'b0, fcdma_pkg::MODE_BLOCK, 1'b0, 16'h0040, 16'h0001);
    sw(4'h1);
    wait_tc(0);
    repeat (6) @(negedge clock);
    mem2mem_en = 1'b0;
    check(mem(16'h7800), 16'h007C);
    check(mem(16'h7801), 16'h007D);
    $display("copy test done");
  endtask

  task automatic t_prio_auto();
    fcdma_partner_inst.out_q.delete();
    hold_lat = 4'hF;
    first_dack = 4'h0;
    load(2, 1'b1, 1'b0, fcdma_pkg::MODE_BLOCK, 1'b0, 16'h9022, 16'h0000);
    load(1, 1'b1, 1'b0, fcdma_pkg::MODE_BLOCK, 1'b1, 16'h8011, 16'h0000);
    sw(4'h6);
    wait_tc(1);
    check(first_dack, 4'h2);
    check({15'h0, first_hold}, 16'h0001);
    check({15'h0, ch_active[1]}, 16'h0001);
    wait_tc(2);
    sw(4'h2);
    wait_tc(1);
    repeat (8) @(negedge clock);
    check(16'(fcdma_partner_inst.out_q.size()), 16'h0003);
    check(oq(0), 16'h002D);
    check(oq(1), 16'h001E);
    check(oq(2), 16'h002D);
    check(16'(fcdma_partner_inst.bus_bad), 16'h0000);
    $display("priority and reload test done");
  endtask

  initial begin
    repeat (4) @(negedge clock);
    reset_n = 1'b1;
    t_block_out();
    t_single_in();
    t_demand();
    t_copy();
    t_prio_auto();
    close_out();
  end
endmodule
